//--- core/lcdcmd_port.sv
// Command interpreter of a character display driver: decodes host
// command bytes, keeps the address counter and emits RAM writes.
// Assumes one clock, synchronous inputs and a RAM side that may stall.
`timescale 1ns/1ps
`include "lcdcmd_params.svh"

module lcdcmd_port #(
	parameter logic [2:0] DISPLAY_LINES = `LCDC_LINES_DEF
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Host byte port
	input wire logic host_valid_in,
	input wire logic host_cmd_data_select_in,
	input wire logic [7:0] host_byte_in,
	output logic host_ready_out,
	// RAM write side
	input wire logic ram_ready_in,
	output logic ram_wr_out,
	output lcdcmd_pkg::lcdcmd_addr_t ram_addr_out,
	output logic [7:0] ram_data_out,
	output lcdcmd_pkg::lcdcmd_region_e ram_region_out,
	// Display drive hints
	input wire logic seg_src_symbol_in,
	output logic seg_reverse_out,
	output logic com_reverse_out,
	output logic user_char_ram_enable_out,
	output logic [1:0] rom_bank_out,
	// Mode and cursor state
	output logic extended_space_select_out,
	output logic display_on_out,
	output logic cursor_on_out,
	output logic cursor_blink_out,
	output logic cursor_visible_out,
	output logic [2:0] cursor_line_out,
	output logic [3:0] cursor_col_out,
	output logic symbol_blink_out,
	output lcdcmd_pkg::lcdcmd_addr_t addr_counter_out,
	output logic test_mode_out
);
	import lcdcmd_pkg::*;

	// ==================================================
	// Address map decode, shared by write path and cursor
	function automatic lcdcmd_region_e region_of(input logic ext, input lcdcmd_addr_t a);
		lcdcmd_region_e r;
		r = LCDC_REG_UNUSED;
		if (ext)
		begin
			if (a <= `LCDC_UC_LAST)
				r = LCDC_REG_UCRAM;
			else if (a >= `LCDC_SYM_FIRST)
				r = LCDC_REG_SYMBOL;
		end
		else
		begin
			if (a <= `LCDC_SI_LAST)
				r = LCDC_REG_ICON;
			else if (a >= `LCDC_ICONBLK_FIRST && a <= `LCDC_ICONBLK_LAST)
				r = LCDC_REG_BLINK;
			else if (a == `LCDC_CONTRAST_ADDR)
				r = LCDC_REG_CONTRAST;
			else if (a == `LCDC_TEST_ADDR)
				r = LCDC_REG_TEST;
			else if (a >= `LCDC_DD_FIRST)
				r = LCDC_REG_DISPDATA;
		end
		return r;
	endfunction

	// ==================================================
	// Buffer between host pins and the engine
	lcdcmd_byte_if host_if ();
	lcdcmd_byte_if eng_if ();

	assign host_if.valid = host_valid_in;
	assign host_if.sel = host_cmd_data_select_in;
	assign host_if.data = host_byte_in;
	assign host_ready_out = host_if.ready;

	lcdcmd_buf #(
		.DEPTH(2),
		.WIDTH(9)
	) u_buf (
		.mclk_in(mclk_in),
		.reset_in(reset_in),
		.up(host_if),
		.dn(eng_if)
	);

	// ==================================================
	// State
	lcdcmd_state_e state_r, state_nxt; // Write engine
	lcdcmd_addr_t addr_r, addr_nxt; // Address counter
	logic ext_r, ext_nxt; // Extended space select
	logic ss_r, ss_nxt; // Segment direction
	logic cs_r, cs_nxt; // Common direction
	logic ucen_r, ucen_nxt; // User RAM enable
	logic [1:0] rom_r, rom_nxt; // Option ROM bank
	logic disp_r, disp_nxt; // Display on
	logic con_r, con_nxt; // Cursor on
	logic cbl_r, cbl_nxt; // Cursor blink
	logic test_r, test_nxt; // Test mode latch
	logic wr_r, wr_nxt; // RAM write pending
	lcdcmd_addr_t wa_r, wa_nxt; // Write address
	logic [7:0] wd_r, wd_nxt; // Write data
	lcdcmd_region_e wg_r, wg_nxt; // Write target
	logic segr_r, segr_nxt; // Segment reverse as driven
	logic vis_r, vis_nxt; // Cursor shown
	logic [2:0] line_r, line_nxt; // Cursor line
	logic [3:0] col_r, col_nxt; // Cursor column
	logic sblk_r, sblk_nxt; // Symbol blink at cursor

	logic eng_rdy; // Engine can take a byte
	logic take; // Byte taken this cycle
	lcdcmd_region_e cur_reg; // Region under the new counter
	logic [3:0] hi; // Upper nibble of the byte

	// Stall only while a write waits on the RAM side
	assign eng_rdy = (state_r == LCDC_ST_IDLE) | ram_ready_in;
	assign eng_if.ready = eng_rdy;
	assign take = eng_if.valid & eng_rdy;
	assign hi = eng_if.data[7:4];

	// ==================================================
	// Decode and next values
	always_comb
	begin
		state_nxt = state_r;
		addr_nxt = addr_r;
		ext_nxt = ext_r;
		ss_nxt = ss_r;
		cs_nxt = cs_r;
		ucen_nxt = ucen_r;
		rom_nxt = rom_r;
		disp_nxt = disp_r;
		con_nxt = con_r;
		cbl_nxt = cbl_r;
		test_nxt = test_r;
		wr_nxt = wr_r;
		wa_nxt = wa_r;
		wd_nxt = wd_r;
		wg_nxt = wg_r;
		// Retire a finished RAM write
		case (state_r)
			LCDC_ST_IDLE:
			begin
				wr_nxt = 1'b0;
			end
			LCDC_ST_WRITE:
			begin
				if (ram_ready_in)
				begin
					wr_nxt = 1'b0;
					state_nxt = LCDC_ST_IDLE;
				end
			end
			default:
			begin
				wr_nxt = 1'b0;
				state_nxt = LCDC_ST_IDLE;
			end
		endcase
		if (take)
		begin
			if (eng_if.sel)
			begin
				// Data byte; extended bit left alone
				if (region_of(ext_r, addr_r) != LCDC_REG_UNUSED)
				begin
					wr_nxt = 1'b1;
					wa_nxt = addr_r;
					wd_nxt = eng_if.data;
					wg_nxt = region_of(ext_r, addr_r);
					state_nxt = LCDC_ST_WRITE;
				end
				addr_nxt = lcdcmd_addr_t'(addr_r + 7'h01);
			end
			else if (eng_if.data[`LCDC_OP_ADDR_BIT])
				addr_nxt = eng_if.data[6:0];
			else if (eng_if.data == `LCDC_NOP)
				test_nxt = 1'b0;
			else if (hi == `LCDC_HI_TEST)
				test_nxt = 1'b1;
			else if (hi == `LCDC_HI_ONOFF)
			begin
				con_nxt = eng_if.data[`LCDC_ONOFF_CURSOR];
				cbl_nxt = eng_if.data[`LCDC_ONOFF_BLINK];
				ext_nxt = eng_if.data[`LCDC_ONOFF_EXT];
				disp_nxt = eng_if.data[`LCDC_ONOFF_DISP];
			end
			else if (hi == `LCDC_HI_SYSSET)
			begin
				if (ext_r)
					ss_nxt = eng_if.data[`LCDC_SYS_SEGDIR];
				else
				begin
					rom_nxt = eng_if.data[`LCDC_SYS_ROM_HI:`LCDC_SYS_ROM_LO];
					cs_nxt = eng_if.data[`LCDC_SYS_COMDIR];
					ucen_nxt = eng_if.data[`LCDC_SYS_UCRAM];
				end
			end
		end
	end

	// ==================================================
	// Drive-side views of the new state
	always_comb
	begin
		cur_reg = region_of(ext_nxt, addr_nxt);
		line_nxt = 3'(addr_nxt[6:4] - `LCDC_DD_ROW0);
		col_nxt = addr_nxt[3:0];
		// Only display data on a shown line or a symbol may carry the cursor
		vis_nxt = con_nxt & (((cur_reg == LCDC_REG_DISPDATA) && (line_nxt < DISPLAY_LINES))
			|| (cur_reg == LCDC_REG_SYMBOL));
		sblk_nxt = con_nxt & cbl_nxt & (cur_reg == LCDC_REG_SYMBOL);
		// Symbol fetches are never mirrored
		segr_nxt = ss_nxt & ~seg_src_symbol_in;
	end

	// Register stage
	always_ff @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			state_r <= LCDC_ST_IDLE;
			addr_r <= `LCDC_RST_ADDR;
			ext_r <= `LCDC_RST_BIT;
			ss_r <= `LCDC_RST_BIT;
			cs_r <= `LCDC_RST_BIT;
			ucen_r <= `LCDC_RST_BIT;
			rom_r <= `LCDC_RST_ROM;
			disp_r <= `LCDC_RST_BIT;
			con_r <= `LCDC_RST_BIT;
			cbl_r <= `LCDC_RST_BIT;
			test_r <= `LCDC_RST_BIT;
			wr_r <= 1'b0;
			wa_r <= `LCDC_RST_ADDR;
			wd_r <= 8'h00;
			wg_r <= LCDC_REG_UNUSED;
			segr_r <= 1'b0;
			vis_r <= 1'b0;
			line_r <= 3'h0;
			col_r <= 4'h0;
			sblk_r <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			addr_r <= addr_nxt;
			ext_r <= ext_nxt;
			ss_r <= ss_nxt;
			cs_r <= cs_nxt;
			ucen_r <= ucen_nxt;
			rom_r <= rom_nxt;
			disp_r <= disp_nxt;
			con_r <= con_nxt;
			cbl_r <= cbl_nxt;
			test_r <= test_nxt;
			wr_r <= wr_nxt;
			wa_r <= wa_nxt;
			wd_r <= wd_nxt;
			wg_r <= wg_nxt;
			segr_r <= segr_nxt;
			vis_r <= vis_nxt;
			line_r <= line_nxt;
			col_r <= col_nxt;
			sblk_r <= sblk_nxt;
		end
	end

	// ==================================================
	// Outputs, all from flops
	assign ram_wr_out = wr_r;
	assign ram_addr_out = wa_r;
	assign ram_data_out = wd_r;
	assign ram_region_out = wg_r;
	assign seg_reverse_out = segr_r;
	assign com_reverse_out = cs_r;
	assign user_char_ram_enable_out = ucen_r;
	assign rom_bank_out = rom_r;
	assign extended_space_select_out = ext_r;
	assign display_on_out = disp_r;
	assign cursor_on_out = con_r;
	assign cursor_blink_out = cbl_r;
	assign cursor_visible_out = vis_r;
	assign cursor_line_out = line_r;
	assign cursor_col_out = col_r;
	assign symbol_blink_out = sblk_r;
	assign addr_counter_out = addr_r;
	assign test_mode_out = test_r;

	// ==================================================
	// Checks
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (reset_in);

	logic tk_cmd, tk_dat; // Helper views of a taken byte
	lcdcmd_addr_t tk_addr;
	assign tk_cmd = take & ~eng_if.sel;
	assign tk_dat = take & eng_if.sel;
	assign tk_addr = eng_if.data[6:0];

	property p_addr_load;
		tk_cmd && eng_if.data[7] |=> addr_counter_out == $past(tk_addr);
	endproperty
	a_addr_load: assert property (p_addr_load) else $error("address set not loaded");

	property p_wrap;
		tk_dat |=> addr_counter_out == lcdcmd_addr_t'($past(addr_counter_out) + 7'h01);
	endproperty
	a_wrap: assert property (p_wrap) else $error("counter step wrong");

	property p_keep_ext;
		tk_dat |=> $stable(extended_space_select_out);
	endproperty
	a_keep_ext: assert property (p_keep_ext) else $error("data write moved ext");

	property p_drop_unused;
		tk_dat && region_of(ext_r, addr_r) == LCDC_REG_UNUSED && !ram_wr_out
			|=> !ram_wr_out;
	endproperty
	a_drop_unused: assert property (p_drop_unused) else $error("unused write issued");

	property p_store;
		tk_dat && region_of(ext_r, addr_r) != LCDC_REG_UNUSED
			|=> ram_wr_out && ram_addr_out == $past(addr_counter_out);
	endproperty
	a_store: assert property (p_store) else $error("data not stored");

	property p_nop;
		tk_cmd && eng_if.data == `LCDC_NOP |=> !test_mode_out;
	endproperty
	a_nop: assert property (p_nop) else $error("nop left test mode");

	property p_ext_set;
		tk_cmd && hi == `LCDC_HI_ONOFF
			|=> extended_space_select_out == $past(eng_if.data[`LCDC_ONOFF_EXT]);
	endproperty
	a_ext_set: assert property (p_ext_set) else $error("ext bit not taken");

	property p_segdir;
		tk_cmd && ext_r && hi == `LCDC_HI_SYSSET && !seg_src_symbol_in
			|=> seg_reverse_out == $past(eng_if.data[`LCDC_SYS_SEGDIR]);
	endproperty
	a_segdir: assert property (p_segdir) else $error("segment dir wrong");

	property p_sym_normal;
		seg_src_symbol_in |=> !seg_reverse_out;
	endproperty
	a_sym_normal: assert property (p_sym_normal) else $error("symbol mirrored");

	property p_cursor_hide;
		!extended_space_select_out && addr_counter_out < `LCDC_DD_FIRST |-> !cursor_visible_out;
	endproperty
	a_cursor_hide: assert property (p_cursor_hide) else $error("cursor on icon space");

	property p_comdir;
		tk_cmd && !ext_r && hi == `LCDC_HI_SYSSET
			|=> com_reverse_out == $past(eng_if.data[`LCDC_SYS_COMDIR]);
	endproperty
	a_comdir: assert property (p_comdir) else $error("common dir wrong");
endmodule // lcdcmd_port

//--- inc/lcdcmd_params.svh
// Constants of the character display command port: opcodes, field
// positions, address map bounds and reset values.
// Assumes inclusion by bare name from the package and the design files.
`ifndef LCDCMD_PARAMS_SVH
`define LCDCMD_PARAMS_SVH

// ==================================================
// Command codes and field positions
`define LCDC_ADDR_SET_BIT 3
`define LCDC_OP_ADDR_BIT 7
`define LCDC_HI_TEST 4'h0
`define LCDC_HI_ONOFF 4'h3
`define LCDC_HI_SYSSET 4'h6
`define LCDC_NOP 8'h00
`define LCDC_ONOFF_CURSOR 3
`define LCDC_ONOFF_BLINK 2
`define LCDC_ONOFF_EXT 1
`define LCDC_ONOFF_DISP 0
`define LCDC_SYS_ROM_HI 3
`define LCDC_SYS_ROM_LO 2
`define LCDC_SYS_COMDIR 1
`define LCDC_SYS_UCRAM 0
`define LCDC_SYS_SEGDIR 1

// ==================================================
// Address map bounds
`define LCDC_SI_LAST 7'h01
`define LCDC_ICONBLK_FIRST 7'h02
`define LCDC_ICONBLK_LAST 7'h03
`define LCDC_CONTRAST_ADDR 7'h08
`define LCDC_TEST_ADDR 7'h09
`define LCDC_DD_FIRST 7'h30
`define LCDC_DD_ROW0 3'h3
`define LCDC_UC_LAST 7'h2f
`define LCDC_SYM_FIRST 7'h60
`define LCDC_LINES_DEF 3'h4

// ==================================================
// Reset values
`define LCDC_RST_ADDR 7'h00
`define LCDC_RST_BIT 1'b0
`define LCDC_RST_ROM 2'h0

`endif

//--- inc/lcdcmd_pkg.sv
// Types shared by the command port and its buffer.
// Assumes the params header sits on the include path.
`include "lcdcmd_params.svh"

package lcdcmd_pkg;

	// ==================================================
	// Target of a data byte in the address map
	typedef enum logic [2:0] {
		LCDC_REG_UNUSED = 3'h0,
		LCDC_REG_ICON = 3'h1,
		LCDC_REG_BLINK = 3'h2,
		LCDC_REG_CONTRAST = 3'h3,
		LCDC_REG_TEST = 3'h4,
		LCDC_REG_DISPDATA = 3'h5,
		LCDC_REG_UCRAM = 3'h6,
		LCDC_REG_SYMBOL = 3'h7
	} lcdcmd_region_e;

	// ==================================================
	// Write engine states, one-hot
	typedef enum logic [1:0] {
		LCDC_ST_IDLE = 2'b01,
		LCDC_ST_WRITE = 2'b10
	} lcdcmd_state_e;

	// Address counter word
	typedef logic [6:0] lcdcmd_addr_t;

endpackage

//--- inc/lcdcmd_byte_if.sv
// Carrier for one host byte with its command/data select and handshake.
// Assumes a single clock; the ready side is driven by the receiver.
`timescale 1ns/1ps

interface lcdcmd_byte_if;
	logic valid; // Byte offered
	logic ready; // Receiver can take it
	logic sel; // High for data, low for command
	logic [7:0] data; // Byte value

	// Offering side
	modport src (output valid, output sel, output data, input ready);
	// Taking side
	modport snk (input valid, input sel, input data, output ready);
endinterface

//--- core/lcdcmd_buf.sv
// Small FIFO between the host port and the command engine.
// Assumes one clock; ready on the filling side is a flip-flop.
`timescale 1ns/1ps

module lcdcmd_buf #(
	parameter int DEPTH = 2,
	parameter int WIDTH = 9
) (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Filling and draining sides
	lcdcmd_byte_if.snk up,
	lcdcmd_byte_if.src dn
);
	import lcdcmd_pkg::*;

	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem_r [DEPTH]; // Storage words
	logic [WIDTH-1:0] mem_nxt [DEPTH];
	logic [PW-1:0] wp_r, wp_nxt; // Write pointer
	logic [PW-1:0] rp_r, rp_nxt; // Read pointer
	logic [PW:0] cnt_r, cnt_nxt; // Fill level
	logic rdy_r, rdy_nxt; // Registered not-full
	logic push, pop;

	assign up.ready = rdy_r;
	assign dn.valid = (cnt_r != '0);
	assign dn.sel = mem_r[rp_r][WIDTH-1];
	assign dn.data = mem_r[rp_r][7:0];
	assign push = up.valid & rdy_r;
	assign pop = dn.valid & dn.ready;

	// ==================================================
	// Next pointers, level and storage
	always_comb
	begin
		mem_nxt = mem_r;
		wp_nxt = wp_r;
		rp_nxt = rp_r;
		if (push)
		begin
			mem_nxt[wp_r] = {up.sel, up.data};
			wp_nxt = (wp_r == PW'(DEPTH - 1)) ? '0 : PW'(wp_r + 1'b1);
		end
		if (pop)
			rp_nxt = (rp_r == PW'(DEPTH - 1)) ? '0 : PW'(rp_r + 1'b1);
		cnt_nxt = (PW+1)'(cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop});
		// Registered so the host sees a clean flop; taken from the next level, so every slot can fill
		rdy_nxt = (cnt_nxt != (PW+1)'(DEPTH));
	end

	// Register stage
	always_ff @(posedge mclk_in)
	begin
		mem_r <= mem_nxt;
		if (reset_in)
		begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
			rdy_r <= 1'b0;
		end
		else
		begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
			rdy_r <= rdy_nxt;
		end
	end
endmodule // lcdcmd_buf

//--- test/lcdcmd_host_model.sv
// Host processor model that offers command and data bytes to the port.
// Assumes one clock; bytes are queued by the bench through send().
`timescale 1ns/1ps

module lcdcmd_host_model (
	// Clock and reset
	input wire logic mclk_in,
	input wire logic reset_in,
	// Byte port toward the device
	input wire logic ready_in,
	output logic valid_out,
	output logic sel_out,
	output logic [7:0] byte_out
);
	logic [8:0] pend_q[$]; // Waiting bytes, select in bit 8

	initial
	begin
		valid_out = 1'b0;
		sel_out = 1'b0;
		byte_out = 8'h00;
	end

	// Bench orders bytes; address set always leads a data burst
	task automatic send(input logic sel, input logic [7:0] b);
		pend_q.push_back({sel, b});
	endtask

	// ==================================================
	// Offer, hold until taken, then next or release
	// Commands are whole bytes at the take edge, test codes included
	always @(posedge mclk_in)
	begin
		if (reset_in)
		begin
			valid_out <= 1'b0;
		end
		else if (!valid_out || ready_in)
		begin
			if (pend_q.size() != 0)
			begin
				{sel_out, byte_out} <= pend_q.pop_front();
				valid_out <= 1'b1;
			end
			else if (valid_out)
			begin
				// Released bus shows garbage, not the old byte
				byte_out <= ~byte_out;
				valid_out <= 1'b0;
			end
		end
	end
endmodule // lcdcmd_host_model

//--- test/lcdcmd_port_test.sv
// Self-checking bench of the command port with a host model.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
`define CHECK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; \
	$display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end

module lcdcmd_port_test;
	import lcdcmd_pkg::*;

	// ==================================================
	// Signals
	logic mclk_in = 1'b0;
	logic reset_in = 1'b1;
	logic host_valid, host_sel, host_ready;
	logic [7:0] host_byte;
	logic ram_ready_in = 1'b1;
	logic ram_wr_out, seg_src = 1'b0;
	lcdcmd_addr_t ram_addr_out, ctr_out;
	logic [7:0] ram_data_out;
	lcdcmd_region_e ram_region_out;
	logic seg_rev, com_rev, ucram, ext_out, disp_on, cur_on, cur_blink;
	logic cur_vis, sym_blink, test_mode;
	logic [1:0] rom_bank;
	logic [2:0] cur_line;
	logic [3:0] cur_col;
	logic [1:0] rdy_mode = 2'h0; // 0 ready, 1 random, 2 stalled
	logic [17:0] exp_q[$]; // Expected region, address, data
	logic [17:0] exp_w;
	logic ext_m = 1'b0; // Bench copy of the extended bit
	logic [6:0] ctr_m = 7'h00; // Bench copy of the counter
	int failures = 0;
	int comparisons = 0;

	// Clock of 8 ns
	always #4 mclk_in = ~mclk_in;

	lcdcmd_host_model host_u (.mclk_in(mclk_in), .reset_in(reset_in), .ready_in(host_ready),
		.valid_out(host_valid), .sel_out(host_sel), .byte_out(host_byte));

	lcdcmd_port dut_u (.mclk_in(mclk_in), .reset_in(reset_in), .host_valid_in(host_valid),
		.host_cmd_data_select_in(host_sel), .host_byte_in(host_byte),
		.host_ready_out(host_ready), .ram_ready_in(ram_ready_in), .ram_wr_out(ram_wr_out),
		.ram_addr_out(ram_addr_out), .ram_data_out(ram_data_out),
		.ram_region_out(ram_region_out), .seg_src_symbol_in(seg_src),
		.seg_reverse_out(seg_rev), .com_reverse_out(com_rev),
		.user_char_ram_enable_out(ucram), .rom_bank_out(rom_bank),
		.extended_space_select_out(ext_out), .display_on_out(disp_on),
		.cursor_on_out(cur_on), .cursor_blink_out(cur_blink), .cursor_visible_out(cur_vis),
		.cursor_line_out(cur_line), .cursor_col_out(cur_col), .symbol_blink_out(sym_blink),
		.addr_counter_out(ctr_out), .test_mode_out(test_mode));

	// RAM side readiness, random or held low when stalling is wanted
	always @(posedge mclk_in)
		ram_ready_in <= (rdy_mode == 2'h0) ? 1'b1 : (rdy_mode == 2'h1) ? 1'($urandom) : 1'b0;

	// ==================================================
	// Watcher: each completed write takes the oldest note
	always @(posedge mclk_in)
	begin
		if (!reset_in && ram_wr_out && ram_ready_in)
		begin
			exp_w = (exp_q.size() != 0) ? exp_q.pop_front() : 18'h3ffff;
			`CHECK({ram_region_out, ram_addr_out, ram_data_out}, exp_w)
		end
	end

	// Target of a data byte, worked out from the map
	function automatic logic [2:0] region(input logic e, input logic [6:0] a);
		if (e)
			return (a < 7'h30) ? 3'h6 : (a >= 7'h60) ? 3'h7 : 3'h0;
		if (a[6:4] >= 3'h3)
			return 3'h5;
		if (a[6:4] != 3'h0)
			return 3'h0;
		case (a[3:0])
			4'h0, 4'h1: return 3'h1;
			4'h2, 4'h3: return 3'h2;
			4'h8: return 3'h3;
			4'h9: return 3'h4;
			default: return 3'h0;
		endcase
	endfunction

	// Command byte, bench copy follows it
	task automatic cmd(input logic [7:0] b);
		host_u.send(1'b0, b);
		if (b[7])
			ctr_m = b[6:0];
		if (b[7:4] == 4'h3)
			ext_m = b[1];
	endtask

	// Data byte, note expected write unless unused
	task automatic dat(input logic [7:0] b);
		host_u.send(1'b1, b);
		if (region(ext_m, ctr_m) != 3'h0)
			exp_q.push_back({region(ext_m, ctr_m), ctr_m, b});
		ctr_m = ctr_m + 7'h01;
	endtask

	// Bounded wait until the host and RAM side are quiet
	task automatic settle();
		int n;
		n = 0;
		while ((host_valid || host_u.pend_q.size() != 0 || ram_wr_out) && n < 500)
		begin
			@(posedge mclk_in);
			n++;
		end
		// A quiet bus never reached counts as a mismatch
		if (n >= 500)
			failures++;
		repeat (8) @(posedge mclk_in);
	endtask

	task automatic conclude();
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Hang guard, well past the length of all tests
	initial
	begin
		repeat (20000) @(posedge mclk_in);
		failures++;
		conclude();
	end

	// ==================================================
	// Main sequence
	initial
	begin
		logic [7:0] tbl[13];
		void'($urandom(32'ha511));
		repeat (16) @(posedge mclk_in);
		reset_in <= 1'b0;
		settle();
		`CHECK({ctr_out, ext_out, cur_vis, test_mode}, 10'h000)
		$display("test reset done");
		// System set one, every code of the low nibble
		cmd(8'h31);
		for (int i = 0; i < 16; i++)
		begin
			cmd(8'h60 | 8'(i));
			settle();
			`CHECK({rom_bank, com_rev, ucram}, 4'(i))
		end
		// System set two: only bit one counts, other state kept
		cmd(8'h33);
		cmd(8'h6d);
		settle();
		`CHECK({seg_rev, com_rev, rom_bank}, 4'h7)
		cmd(8'h62);
		settle();
		`CHECK(seg_rev, 1'b1)
		seg_src <= 1'b1;
		repeat (3) @(posedge mclk_in);
		`CHECK(seg_rev, 1'b0)
		seg_src <= 1'b0;
		$display("test system set done");
		// Map walk; test register never hit, user fill stops below 30H
		tbl = '{8'h00, 8'h02, 8'h07, 8'h10, 8'h30, 8'h45, 8'h5f, 8'h7e,
			8'h80, 8'hae, 8'hb0, 8'he0, 8'hff};
		foreach (tbl[i])
		begin
			cmd(8'h31 | {6'h00, tbl[i][7], 1'b0});
			cmd(8'h80 | tbl[i]);
			dat(8'($urandom));
			dat(8'($urandom));
			settle();
			`CHECK(ext_out, tbl[i][7])
			`CHECK(ctr_out, ctr_m)
		end
		$display("test map done");
		// Cursor follows the counter
		cmd(8'h3d);
		cmd(8'hb5);
		settle();
		`CHECK({cur_vis, cur_line, cur_col}, 8'h85)
		cmd(8'hf5);
		settle();
		`CHECK({cur_vis, cur_line, cur_col}, 8'h45)
		cmd(8'he5);
		settle();
		`CHECK({cur_vis, cur_line, cur_col}, 8'hb5)
		cmd(8'h80);
		settle();
		`CHECK(cur_vis, 1'b0)
		cmd(8'h3f);
		cmd(8'hb0);
		settle();
		`CHECK(cur_vis, 1'b0)
		cmd(8'h85);
		settle();
		`CHECK(cur_vis, 1'b0)
		cmd(8'he5);
		settle();
		`CHECK({sym_blink, cur_on, cur_blink, disp_on}, 4'hf)
		$display("test cursor done");
		// Stray test code, then the idle code clears it
		cmd(8'h05);
		settle();
		`CHECK(test_mode, 1'b1)
		cmd(8'h00);
		settle();
		`CHECK({test_mode, ctr_out}, {1'b0, ctr_m})
		$display("test idle code done");
		// Stalled RAM side fills the buffer, then drains
		cmd(8'h31);
		cmd(8'hb0);
		rdy_mode <= 2'h2;
		for (int i = 0; i < 6; i++)
			dat(8'(i * 17));
		repeat (20) @(posedge mclk_in);
		`CHECK(host_ready, 1'b0)
		rdy_mode <= 2'h0;
		settle();
		`CHECK(ctr_out, 7'h36)
		// Random data with random stalls, back to back
		rdy_mode <= 2'h1;
		cmd(8'hc0);
		for (int i = 0; i < 24; i++)
			dat(8'($urandom));
		repeat (120) @(posedge mclk_in);
		rdy_mode <= 2'h0;
		settle();
		`CHECK(ctr_out, 7'h58)
		`CHECK(exp_q.size(), 0)
		$display("test stall done");
		conclude();
	end
endmodule // lcdcmd_port_test
